// >>> rtl/input_trigger_qualifier.sv
// Overview of operation
// R1: low level mode triggers while input low
// R2: high level mode triggers while input high
// R3: falling edge mode pulses once per fall
// R4: rising edge mode pulses once per rise
// R5: analogue input 1 debounce 0..1000 ms, default 0
// R6: trigger needs prior level held debounce time
// R7: digital inputs: low, high, fall, rise, none
// R8: same debounce range for digital inputs
// R9: input 1 mode choice, default low
// R10: front button actions, default none
// R11: supply select applies only on leaving
// R12: reset trigger goes to zero or preset
// R13: peak shown while held, 20 s after
// R14: mode none never triggers
// R15: debounce counts ms ticks, restarts on change
module input_trigger_qualifier #(
  parameter int TICK_CYCLES = qual_pkg::TICK_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic ana_in1,
  input wire logic [2:0] dig_in,
  input wire logic btn_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [3:0] trig_out,
  output logic reset_zero_pulse,
  output logic reset_preset_pulse,
  output logic alarm_ack_pulse,
  output logic peak_show,
  output logic valley_show,
  output logic [1:0] supply_sel
);

  function automatic logic level_hit(input qual_pkg::trig_mode_t m, input logic lv);
    level_hit = (m == qual_pkg::TRIG_LOW && !lv) || (m == qual_pkg::TRIG_HIGH && lv);
  endfunction

  function automatic logic edge_dir(input qual_pkg::trig_mode_t m, input logic lv);
    edge_dir = (m == qual_pkg::TRIG_FALL && !lv) || (m == qual_pkg::TRIG_RISE && lv);
  endfunction

  function automatic logic mode_ok(input int k, input logic [2:0] v);
    mode_ok = (v <= 3'(qual_pkg::TRIG_NONE)) && !(k == 0 && v == 3'(qual_pkg::TRIG_NONE));
  endfunction

  function automatic logic [9:0] clamp_ms(input logic [31:0] v);
    clamp_ms = (v > 32'(qual_pkg::DEB_MAX_MS)) ? qual_pkg::DEB_MAX_MS : v[9:0];
  endfunction

  qual_pkg::trig_mode_t mode_reg [4];
  logic [9:0] deb_in1_reg;
  logic [9:0] deb_dig_reg;
  qual_pkg::btn_action_t action_reg;
  logic preset_choice_reg;
  qual_pkg::supply_t pending_sup_reg;
  qual_pkg::supply_t supply_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] tick_cnt_reg;
  logic tick_reg;
  logic [3:0] lvl_reg;
  logic [3:0] armed_reg;
  logic [3:0] trig_reg;
  logic [9:0] cnt_reg [4];
  logic btn_reg;
  qual_pkg::mem_state_t mem_state_reg;
  qual_pkg::mem_state_t mem_state_next;
  logic kind_reg;
  logic toggle_reg;
  logic [14:0] hold_reg;
  logic rst_zero_reg;
  logic rst_preset_reg;
  logic ack_reg;
  logic peak_reg;
  logic valley_reg;

  qual_pkg::chan_cfg_t cfg [4];
  logic [3:0] in_lvl;
  logic [3:0] changed;
  logic [3:0] accept;
  logic [3:0] active;
  logic [3:0] edge_hit;
  logic [3:0] armed_next;
  logic [3:0] trig_next;
  logic [9:0] cnt_next [4];

  // apb decode
  wire setup = psel && !penable;
  wire access_done = psel && penable && pready_reg;
  wire wr_en = access_done && pwrite;
  wire hit_mode = (paddr == qual_pkg::MODE_OFS);
  wire hit_deb1 = (paddr == qual_pkg::DEB_IN1_OFS);
  wire hit_debd = (paddr == qual_pkg::DEB_DIG_OFS);
  wire hit_act = (paddr == qual_pkg::ACTION_OFS);
  wire hit_sup = (paddr == qual_pkg::SUPPLY_OFS);
  wire hit_stat = (paddr == qual_pkg::STATUS_OFS);
  wire addr_hit = hit_mode || hit_deb1 || hit_debd || hit_act || hit_sup || hit_stat;
  wire act_legal = (pwdata[2:0] <= 3'(qual_pkg::BTN_RESET_PRESET));
  wire sup_legal = (pwdata[1:0] <= 2'(qual_pkg::SUPPLY_18V));
  wire commit = wr_en && hit_sup && pwdata[qual_pkg::SUP_COMMIT_BIT];
  wire [1:0] commit_val = sup_legal ? pwdata[1:0] : 2'(pending_sup_reg);

  wire [31:0] mode_rd = {16'h0000, 1'b0, mode_reg[3], 1'b0, mode_reg[2],
    1'b0, mode_reg[1], 1'b0, mode_reg[0]};
  wire [31:0] status_rd = {22'h000000, lvl_reg, valley_reg, peak_reg, trig_reg};
  wire [31:0] sup_rd = {14'h0000, supply_reg, 14'h0000, pending_sup_reg};
  wire [31:0] rd_mux =
    hit_mode ? mode_rd :
    hit_deb1 ? {22'h000000, deb_in1_reg} :
    hit_debd ? {22'h000000, deb_dig_reg} :
    hit_act ? {27'h0000000, preset_choice_reg, 1'b0, action_reg} :
    hit_sup ? sup_rd :
    hit_stat ? status_rd : 32'h00000000;

  // front button
  wire press = btn_in && !btn_reg;
  wire mem_action = (action_reg == qual_pkg::BTN_PEAK) ||
    (action_reg == qual_pkg::BTN_VALLEY) || (action_reg == qual_pkg::BTN_TOGGLE);
  wire mem_start = press && mem_action;
  wire press_kind = (action_reg == qual_pkg::BTN_VALLEY) ||
    ((action_reg == qual_pkg::BTN_TOGGLE) && !toggle_reg);
  wire hold_done = tick_reg && (hold_reg == qual_pkg::HOLD_MS - 15'h0001);
  wire kind_next = mem_start ? press_kind : kind_reg;
  wire show_next = (mem_state_next != qual_pkg::MEM_IDLE);

  // digital input 1 acts as the timer reset terminal
  wire rst_start = trig_next[1] && !trig_reg[1];
  wire btn_zero = press && (action_reg == qual_pkg::BTN_RESET_ZERO);
  wire btn_preset = press && (action_reg == qual_pkg::BTN_RESET_PRESET);

  assign in_lvl = {dig_in, ana_in1};

  for (genvar k = 0; k < 4; k++)
  begin : g_ch
    assign cfg[k] = '{mode: mode_reg[k], debounce_ms: (k == 0) ? deb_in1_reg : deb_dig_reg};
    assign changed[k] = in_lvl[k] ^ lvl_reg[k];
    // R6: prior level held long enough
    assign accept[k] = (cfg[k].debounce_ms == 10'h000) || (cnt_reg[k] >= cfg[k].debounce_ms);
    // R1: low level decode
    // R2: high level decode
    // R14: none matches neither decoder
    assign active[k] = level_hit(cfg[k].mode, in_lvl[k]);
    // R3: falling edge pulse
    // R4: rising edge pulse
    assign edge_hit[k] = changed[k] && accept[k] && edge_dir(cfg[k].mode, in_lvl[k]);
    // level is armed only when entered after a qualified idle period
    assign armed_next[k] = active[k] && (changed[k] ? accept[k] : armed_reg[k]);
    assign trig_next[k] = armed_next[k] || edge_hit[k];
    // R15: ms stable counter, restart on change
    assign cnt_next[k] = changed[k] ? 10'h000 :
      (tick_reg && cnt_reg[k] != qual_pkg::DEB_MAX_MS) ? cnt_reg[k] + 10'h001 : cnt_reg[k];
  end

  // R13: peak or valley display sequencing
  always_comb
  begin
    mem_state_next = mem_state_reg;
    unique case (mem_state_reg)
      qual_pkg::MEM_IDLE:
      begin
        if (mem_start)
          mem_state_next = qual_pkg::MEM_HELD;
      end
      qual_pkg::MEM_HELD:
      begin
        if (!btn_in)
          mem_state_next = qual_pkg::MEM_TIMED;
      end
      qual_pkg::MEM_TIMED:
      begin
        if (mem_start)
          mem_state_next = qual_pkg::MEM_HELD;
        else if (hold_done)
          mem_state_next = qual_pkg::MEM_IDLE;
      end
      default:
        mem_state_next = qual_pkg::MEM_IDLE;
    endcase
  end

  // ms tick; a tick width counter keeps simulation overrides cheap
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    end
    else if (ce)
    begin
      tick_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1));
      tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1)) ? 32'h00000000 :
        tick_cnt_reg + 32'h00000001;
    end
  end

  // apb slave; answer one cycle after setup
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else if (ce)
    begin
      pready_reg <= setup;
      pslverr_reg <= setup && !addr_hit;
      if (setup)
        prdata_reg <= rd_mux;
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int k = 0; k < 4; k++)
        mode_reg[k] <= qual_pkg::MODE_RST;
      deb_in1_reg <= qual_pkg::DEB_RST;
      deb_dig_reg <= qual_pkg::DEB_RST;
      action_reg <= qual_pkg::ACTION_RST;
      preset_choice_reg <= 1'b0;
      pending_sup_reg <= qual_pkg::SUPPLY_RST;
      supply_reg <= qual_pkg::SUPPLY_RST;
    end
    else if (ce && wr_en)
    begin
      // R7: per digital input mode select
      // R9: input 1 refuses the none code
      for (int k = 0; k < 4; k++)
        if (hit_mode && mode_ok(k, pwdata[k * qual_pkg::MODE_FIELD_W +: 3]))
          mode_reg[k] <= qual_pkg::trig_mode_t'(pwdata[k * qual_pkg::MODE_FIELD_W +: 3]);
      // R5: input 1 debounce clamped to range
      if (hit_deb1)
        deb_in1_reg <= clamp_ms(pwdata);
      // R8: shared digital debounce
      if (hit_debd)
        deb_dig_reg <= clamp_ms(pwdata);
      // R10: button action select
      if (hit_act && act_legal)
        action_reg <= qual_pkg::btn_action_t'(pwdata[2:0]);
      if (hit_act)
        preset_choice_reg <= pwdata[qual_pkg::ACT_PRESET_BIT];
      if (hit_sup && sup_legal)
        pending_sup_reg <= qual_pkg::supply_t'(pwdata[1:0]);
      // R11: applied only on leaving
      if (commit)
        supply_reg <= qual_pkg::supply_t'(commit_val);
    end
  end

  // channel qualification; idle level assumed high (pulled up inputs)
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      lvl_reg <= 4'hF;
      armed_reg <= 4'h0;
      trig_reg <= 4'h0;
      for (int k = 0; k < 4; k++)
        cnt_reg[k] <= 10'h000;
    end
    else if (ce)
    begin
      lvl_reg <= in_lvl;
      armed_reg <= armed_next;
      trig_reg <= trig_next;
      for (int k = 0; k < 4; k++)
        cnt_reg[k] <= cnt_next[k];
    end
  end

  // button actions and display memory
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      btn_reg <= 1'b0;
      mem_state_reg <= qual_pkg::MEM_IDLE;
      kind_reg <= 1'b0;
      toggle_reg <= 1'b1;
      hold_reg <= 15'h0000;
      rst_zero_reg <= 1'b0;
      rst_preset_reg <= 1'b0;
      ack_reg <= 1'b0;
      peak_reg <= 1'b0;
      valley_reg <= 1'b0;
    end
    else if (ce)
    begin
      btn_reg <= btn_in;
      mem_state_reg <= mem_state_next;
      kind_reg <= kind_next;
      if (mem_start && action_reg == qual_pkg::BTN_TOGGLE)
        toggle_reg <= press_kind;
      // clear on expiry so the count never reaches the full hold value
      hold_reg <= (mem_state_reg != qual_pkg::MEM_TIMED || hold_done) ? 15'h0000 :
        tick_reg ? hold_reg + 15'h0001 : hold_reg;
      // R12: zero or preset per reset choice
      rst_zero_reg <= (rst_start && !preset_choice_reg) || btn_zero;
      rst_preset_reg <= (rst_start && preset_choice_reg) || btn_preset;
      ack_reg <= press && (action_reg == qual_pkg::BTN_ALARM_ACK);
      peak_reg <= show_next && !kind_next;
      valley_reg <= show_next && kind_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign trig_out = trig_reg;
  assign reset_zero_pulse = rst_zero_reg;
  assign reset_preset_pulse = rst_preset_reg;
  assign alarm_ack_pulse = ack_reg;
  assign peak_show = peak_reg;
  assign valley_show = valley_reg;
  assign supply_sel = supply_reg;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_low_level;
    ce && !psel && lvl_reg[1] == 1'b0 && !dig_in[0] && armed_reg[1] &&
      mode_reg[1] == qual_pkg::TRIG_LOW |=> trig_reg[1];
  endproperty
  a_low_level: assert property (p_low_level) else $error("low level trigger dropped"); // R1

  property p_high_level;
    trig_reg[2] && mode_reg[2] == qual_pkg::TRIG_HIGH && $stable(mode_reg[2]) |-> lvl_reg[2];
  endproperty
  a_high_level: assert property (p_high_level) else $error("high trigger on low input"); // R2

  property p_fall;
    ce && mode_reg[3] == qual_pkg::TRIG_FALL && lvl_reg[3] && !dig_in[2] &&
      deb_dig_reg == 10'h000 |=> trig_reg[3];
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed"); // R3

  property p_rise_once;
    ce && !psel && trig_reg[3] && mode_reg[3] == qual_pkg::TRIG_RISE &&
      $stable(mode_reg[3]) |=> !trig_reg[3];
  endproperty
  a_rise_once: assert property (p_rise_once) else $error("rising pulse too long"); // R4

  property p_deb_range;
    deb_in1_reg <= qual_pkg::DEB_MAX_MS && deb_dig_reg <= qual_pkg::DEB_MAX_MS;
  endproperty
  a_deb_range: assert property (p_deb_range) else $error("debounce out of range"); // R5

  property p_reject;
    ce && mode_reg[1] == qual_pkg::TRIG_FALL && lvl_reg[1] && !dig_in[0] &&
      cnt_reg[1] < deb_dig_reg |=> !trig_reg[1];
  endproperty
  a_reject: assert property (p_reject) else $error("short idle edge accepted"); // R6

  property p_supply_commit;
    !$stable(supply_reg) |-> $past(commit) && $past(ce);
  endproperty
  a_supply_commit: assert property (p_supply_commit) else $error("supply moved early"); // R11

  property p_reset_choice;
    rst_preset_reg |-> $past(preset_choice_reg) || $past(action_reg) == qual_pkg::BTN_RESET_PRESET;
  endproperty
  a_reset_choice: assert property (p_reset_choice) else $error("preset without choice"); // R12

  property p_hold_bound;
    hold_reg < qual_pkg::HOLD_MS && !(peak_reg && valley_reg);
  endproperty
  a_hold_bound: assert property (p_hold_bound) else $error("memory display overrun"); // R13

  property p_none;
    mode_reg[2] == qual_pkg::TRIG_NONE && $stable(mode_reg[2]) |-> !trig_reg[2];
  endproperty
  a_none: assert property (p_none) else $error("none mode triggered"); // R14

  property p_count_hold;
    ce && !changed[2] && !tick_reg |=> cnt_reg[2] == $past(cnt_reg[2]);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved off tick"); // R15

  c_fall_hit: cover property (ce && edge_hit[1]);
  c_rejected: cover property (ce && changed[1] && !accept[1] && deb_dig_reg != 10'h000);
  c_peak_timeout: cover property (mem_state_reg == qual_pkg::MEM_TIMED && hold_done && ce);
  c_supply: cover property (commit && ce);

endmodule

// >>> rtl/qual_pkg.sv
package qual_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] DEB_IN1_OFS = 8'h04;
  localparam logic [7:0] DEB_DIG_OFS = 8'h08;
  localparam logic [7:0] ACTION_OFS = 8'h0C;
  localparam logic [7:0] SUPPLY_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;

  // field positions
  localparam int MODE_FIELD_W = 32'h4;
  localparam int ACT_PRESET_BIT = 32'h4;
  localparam int SUP_COMMIT_BIT = 32'h8;
  localparam int SUP_APPLIED_LSB = 32'h10;
  localparam int STAT_SHOW_LSB = 32'h4;
  localparam int STAT_LVL_LSB = 32'h6;

  typedef enum logic [2:0] {
    TRIG_LOW = 3'h0,
    TRIG_HIGH = 3'h1,
    TRIG_FALL = 3'h2,
    TRIG_RISE = 3'h3,
    TRIG_NONE = 3'h4
  } trig_mode_t;

  typedef enum logic [2:0] {
    BTN_NONE = 3'h0,
    BTN_PEAK = 3'h1,
    BTN_VALLEY = 3'h2,
    BTN_TOGGLE = 3'h3,
    BTN_ALARM_ACK = 3'h4,
    BTN_RESET_ZERO = 3'h5,
    BTN_RESET_PRESET = 3'h6
  } btn_action_t;

  typedef enum logic [1:0] {
    SUPPLY_5V = 2'h0,
    SUPPLY_12V = 2'h1,
    SUPPLY_18V = 2'h2
  } supply_t;

  typedef enum logic [2:0] {
    MEM_IDLE = 3'h1,
    MEM_HELD = 3'h2,
    MEM_TIMED = 3'h4
  } mem_state_t;

  typedef struct packed {
    trig_mode_t mode;
    logic [9:0] debounce_ms;
  } chan_cfg_t;

  // reset values
  localparam trig_mode_t MODE_RST = TRIG_LOW;
  localparam logic [9:0] DEB_RST = 10'h000;
  localparam btn_action_t ACTION_RST = BTN_NONE;
  localparam supply_t SUPPLY_RST = SUPPLY_5V;

  // timing
  localparam logic [9:0] DEB_MAX_MS = 10'h3E8;
  localparam int CLK_PERIOD_NS = 32'h5;
  localparam int TICK_NS = 32'h000F4240;
  localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
  localparam int HOLD_S = 32'h14;
  localparam logic [14:0] HOLD_MS = 15'(HOLD_S * 32'h3E8);

endpackage

// >>> testbench/switch_model.sv
module switch_model (
  input wire logic sys_clk,
  input wire logic [4:0] cmd,
  input wire logic slow,
  output logic ana_in1,
  output logic [2:0] dig_in,
  output logic btn_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] d1 = 5'h0F;
  logic [4:0] d2 = 5'h0F;
  logic [4:0] pins = 5'h0F;
  // contacts open: pull-ups keep inputs high, button released
  always @(posedge sys_clk)
  begin
    d1 <= cmd;
    d2 <= d1;
    pins <= slow ? d2 : cmd;
  end
  assign ana_in1 = pins[0];
  assign dig_in = pins[3:1];
  assign btn_in = pins[4];
endmodule

// >>> testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rerr, rz, rp, ack, pk, vl, ana_in1, btn_in;
  logic [2:0] dig_in;
  logic [3:0] trig_out;
  logic [1:0] supply_sel;
  logic [4:0] cmd = 5'h0F;
  logic slow = 1'b0;
  logic ce = 1'b1;
  int bad_count = 0;
  int n_compared = 0;
  int c[8];
  wire [7:0] obs = {pk, ack, rp, rz, trig_out};

  always #2.5 sys_clk = ~sys_clk;

  switch_model i_sw (.sys_clk(sys_clk), .cmd(cmd), .slow(slow), .ana_in1(ana_in1),
    .dig_in(dig_in), .btn_in(btn_in));

  input_trigger_qualifier #(.TICK_CYCLES(4)) i_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .ana_in1(ana_in1), .dig_in(dig_in), .btn_in(btn_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_out(trig_out), .reset_zero_pulse(rz),
    .reset_preset_pulse(rp), .alarm_ack_pulse(ack), .peak_show(pk),
    .valley_show(vl), .supply_sel(supply_sel));

  task automatic finish_test();
    if (bad_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle so a following call never rewrites psel in the same step
    @(posedge sys_clk);
    if (n >= 20)
    begin
      bad_count++;
      finish_test();
    end
  endtask

  // per-output count of high cycles over a window
  task automatic cnt(input int n);
    c = '{default: 0};
    repeat (n)
    begin
      @(posedge sys_clk);
      for (int i = 0; i < 8; i++)
        c[i] += (obs[i] === 1'b1) ? 1 : 0;
    end
  endtask

  task automatic t_regs();
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rdata, 32'h0);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(rerr), 32'h1);
    apb(1'b1, qual_pkg::DEB_IN1_OFS, 32'h7D0);
    apb(1'b0, qual_pkg::DEB_IN1_OFS, 32'h0);
    chk(rdata, 32'h3E8);
    apb(1'b1, qual_pkg::DEB_IN1_OFS, 32'h0);
    apb(1'b1, qual_pkg::MODE_OFS, 32'h4004);
    apb(1'b0, qual_pkg::MODE_OFS, 32'h0);
    chk(rdata, 32'h4000);
  endtask

  task automatic t_level();
    cmd <= 5'h0B;
    apb(1'b1, qual_pkg::MODE_OFS, 32'h100);
    cmd <= 5'h08;
    cnt(8);
    chk(c[0], 6);
    chk(c[1], 6);
    chk(c[2], 0);
    cmd <= 5'h0F;
    cnt(8);
    chk(c[1], 2);
    chk(c[2], 6);
  endtask

  task automatic t_edge();
    apb(1'b1, qual_pkg::MODE_OFS, 32'h3020);
    cmd <= 5'h0D;
    cnt(6);
    chk(c[1], 1);
    chk(c[4], 1);
    chk(c[5], 0);
    cmd <= 5'h0F;
    cnt(6);
    chk(c[1], 0);
    apb(1'b1, qual_pkg::ACTION_OFS, 32'h10);
    cmd <= 5'h0D;
    cnt(6);
    chk(c[4], 0);
    chk(c[5], 1);
    slow <= 1'b1;
    cmd <= 5'h07;
    cnt(8);
    chk(c[3], 0);
    cmd <= 5'h0F;
    cnt(8);
    chk(c[3], 1);
    slow <= 1'b0;
  endtask

  task automatic t_none();
    apb(1'b1, qual_pkg::MODE_OFS, 32'h4000);
    cmd <= 5'h07;
    cnt(6);
    chk(c[3], 0);
    cmd <= 5'h0F;
    cnt(6);
    chk(c[3], 0);
  endtask

  task automatic t_deb();
    apb(1'b1, qual_pkg::DEB_DIG_OFS, 32'h2);
    apb(1'b1, qual_pkg::MODE_OFS, 32'h20);
    repeat (20) @(posedge sys_clk);
    cmd <= 5'h0D;
    cnt(6);
    chk(c[1], 1);
    cmd <= 5'h0F;
    repeat (2) @(posedge sys_clk);
    cmd <= 5'h0D;
    cnt(6);
    chk(c[1], 0);
    cmd <= 5'h0F;
    apb(1'b1, qual_pkg::DEB_DIG_OFS, 32'h0);
  endtask

  // clock enable low freezes the qualifier
  task automatic t_freeze();
    ce <= 1'b0;
    cmd <= 5'h0D;
    cnt(6);
    chk(c[1], 0);
    ce <= 1'b1;
    cnt(4);
    chk(c[1], 1);
    cmd <= 5'h0F;
  endtask

  task automatic t_supply();
    apb(1'b1, qual_pkg::SUPPLY_OFS, 32'h2);
    repeat (3) @(posedge sys_clk);
    chk(32'(supply_sel), 32'h0);
    apb(1'b1, qual_pkg::SUPPLY_OFS, 32'h102);
    apb(1'b0, qual_pkg::SUPPLY_OFS, 32'h0);
    chk(rdata, 32'h20002);
    chk(32'(supply_sel), 32'h2);
  endtask

  task automatic t_button();
    int acts[4] = '{0, 4, 5, 6};
    foreach (acts[i])
    begin
      apb(1'b1, qual_pkg::ACTION_OFS, 32'(acts[i]));
      cmd <= 5'h1F;
      cnt(6);
      cmd <= 5'h0F;
      chk(32'({c[6] != 0, c[5] != 0, c[4] != 0}),
        32'({acts[i] == 4, acts[i] == 6, acts[i] == 5}));
    end
    apb(1'b1, qual_pkg::ACTION_OFS, 32'h1);
    cmd <= 5'h1F;
    cnt(6);
    chk(32'(c[7] > 2), 32'h1);
    cmd <= 5'h0F;
    cnt(6);
    chk(c[7], 6);
    repeat (80010) @(posedge sys_clk);
    chk(32'(pk), 32'h0);
    apb(1'b1, qual_pkg::ACTION_OFS, 32'h2);
    cmd <= 5'h1F;
    repeat (4) @(posedge sys_clk);
    chk(32'({pk, vl}), 32'h1);
    cmd <= 5'h0F;
    apb(1'b1, qual_pkg::ACTION_OFS, 32'h3);
    cmd <= 5'h1F;
    repeat (4) @(posedge sys_clk);
    chk(32'({pk, vl}), 32'h2);
    cmd <= 5'h0F;
    repeat (4) @(posedge sys_clk);
    cmd <= 5'h1F;
    repeat (4) @(posedge sys_clk);
    chk(32'({pk, vl}), 32'h1);
    cmd <= 5'h0F;
  endtask

  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_level();
    t_edge();
    t_none();
    t_deb();
    t_freeze();
    t_supply();
    t_button();
    finish_test();
  end
endmodule
